// ==== core/sbsel_params.svh ====
// Field codes, bit positions and reset values of the S-Bus source selector.
// Assumes inclusion by its bare name from the selector sources.
`ifndef SBSEL_PARAMS_SVH
`define SBSEL_PARAMS_SVH

// S-Bus field codes handled here
`define SB_INSTR 5'h00
`define SB_PREADD 5'h02
`define SB_GRP1 5'h04
`define SB_UNIT 5'h05
`define SB_GRP2 5'h06
`define SB_DEVNUM 5'h09
`define SB_DIRIN 5'h0A
`define SB_CNTL 5'h0C
`define SB_CNTH 5'h0D
`define SB_KEEP 5'h0F
`define SB_PC 5'h10
`define SB_DBASE 5'h15
`define SB_OPERAND 5'h16
`define SB_COND 5'h17
`define SB_DLIM 5'h1C
`define SB_PBASE 5'h1E
`define SB_NOP 5'h1F

// Field placements inside the S-Bus word
`define SB_COND_SRC_LO 6
`define SB_COND_SRC_HI 7
`define SB_COND_DST_LO 8
`define SB_COND_DST_HI 9
`define SB_COND_ZERO 7
`define SB_CNTH_LO 4
`define SB_CNTH_HI 9
`define SB_CNTL_LO 10
`define SB_CNTL_HI 15
`define SB_DEV_LO 8
`define SB_DEV_HI 15
`define SB_UNIT_LO 4
`define SB_UNIT_HI 7
`define SB_UNIT_FLAG 13

// Reset values
`define SB_HOLD_RST 16'h0000

`endif

// ==== core/sbsel_pkg.sv ====
// Types shared by the S-Bus source selector.
// Assumes the selector sits on the CPU microcycle clock.
package sbsel_pkg;

   // All CPU sources the selector can put onto the S-Bus
   typedef struct packed {
      logic [15:0] current_instruction_reg;
      logic [15:0] special_signals_group_one;
      logic [15:0] special_signals_group_two;
      logic [15:0] data_base_reg;
      logic [15:0] data_limit_reg;
      logic [15:0] direct_input_data_reg;
      logic [15:0] operand_reg;
      logic [15:0] program_counter;
      logic [15:0] pre_adder_output;
      logic [15:0] program_base_reg;
      logic [15:0] status_word;
      logic [5:0] loop_counter_reg;
      logic [7:0] device_number_reg;
      logic [3:0] unit_number_reg;
   } sbsel_src_type;

   // Selector sequencing
   typedef enum logic {
      SBSEL_IDLE,
      SBSEL_WAIT_OPERAND
   } sbsel_state_type;

endpackage

// ==== core/sbsel_top.sv ====
// S-Bus source selector: decodes the S-Bus field and loads the S-Bus word.
// Assumes field code, sources and operand busy come from logic on clk.
// Function
// - Condition code copies status bits 6,7 into bits 8,9, rest cleared.
// - Condition code sets bit 7 when both copied bits are zero.
// - Code 00000 loads the current instruction word.
// - Code 00100 loads special signals group one.
// - Code 00110 loads special signals group two.
// - Code 01101 puts loop counter in bits 4 to 9, rest zero.
// - Code 01100 puts loop counter in bits 10 to 15, rest zero.
// - Code 10101 loads the data base register.
// - Code 11100 loads the data limit register.
// - Code 01001 puts device number in bits 8 to 15, low byte zero.
// - Code 01010 loads the direct input data word of the processor.
// - Code 00101 puts unit number in bits 4 to 7, others zero.
// - Unit number retrieval also forces bit 13 to one.
// - Code 10110 loads the operand register.
// - Operand load during busy operand memory operation freezes until done.
// - Code 10000 loads the program counter.
// - Code 00010 loads the pre-adder output.
// - Code 11110 loads the program base register.
// - Code 01111 keeps the S-Bus word unchanged.
`timescale 1ns/10ps
`include "sbsel_params.svh"

module sbsel_top #(
   parameter int DATA_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic issue_valid,
   input wire logic [4:0] field_code,
   input wire logic operand_busy,
   input wire sbsel_pkg::sbsel_src_type src,
   output logic [15:0] second_bus_hold_q,
   output logic loaded_q,
   output logic freeze_q
);

   // Only the documented 16-bit word is served; refused at elaboration
   if (DATA_W != 16) begin : g_width_check
      $error("sbsel_top serves a 16-bit S-Bus only");
   end

   // Decode one field code; bit 16 says whether a load happens
   function automatic logic [16:0] sbsel_pick(
      input logic [4:0] code,
      input sbsel_pkg::sbsel_src_type s
   );
      logic [15:0] v;
      logic ld;
      v = 16'h0000;
      ld = 1'b1;
      case (code)
         `SB_INSTR: begin
            v = s.current_instruction_reg;
         end
         `SB_GRP1: begin
            v = s.special_signals_group_one;
         end
         `SB_GRP2: begin
            v = s.special_signals_group_two;
         end
         `SB_CNTH: begin
            v[`SB_CNTH_HI:`SB_CNTH_LO] = s.loop_counter_reg;
         end
         `SB_CNTL: begin
            v[`SB_CNTL_HI:`SB_CNTL_LO] = s.loop_counter_reg;
         end
         `SB_DBASE: begin
            v = s.data_base_reg;
         end
         `SB_DLIM: begin
            v = s.data_limit_reg;
         end
         `SB_DEVNUM: begin
            v[`SB_DEV_HI:`SB_DEV_LO] = s.device_number_reg;
         end
         `SB_DIRIN: begin
            v = s.direct_input_data_reg;
         end
         `SB_UNIT: begin
            v[`SB_UNIT_HI:`SB_UNIT_LO] = s.unit_number_reg;
            v[`SB_UNIT_FLAG] = 1'b1;
         end
         `SB_OPERAND: begin
            v = s.operand_reg;
         end
         `SB_PC: begin
            v = s.program_counter;
         end
         `SB_PREADD: begin
            v = s.pre_adder_output;
         end
         `SB_PBASE: begin
            v = s.program_base_reg;
         end
         `SB_COND: begin
            // Condition code moved up, zero flag below it
            v[`SB_COND_DST_HI:`SB_COND_DST_LO] =
               s.status_word[`SB_COND_SRC_HI:`SB_COND_SRC_LO];
            v[`SB_COND_ZERO] =
               ~|s.status_word[`SB_COND_SRC_HI:`SB_COND_SRC_LO];
         end
         `SB_NOP: begin
            ld = 1'b0;
         end
         `SB_KEEP: begin
            ld = 1'b0;
         end
         default: begin
            ld = 1'b0; // Codes served elsewhere leave the word alone
         end
      endcase
      return {ld, v};
   endfunction

   sbsel_pkg::sbsel_state_type state_q;
   sbsel_pkg::sbsel_state_type state_d;
   logic [15:0] hold_d;
   logic loaded_d;
   logic freeze_d;
   logic [16:0] pick;
   logic take;

   // A new field is taken only when enabled and not frozen
   assign take = clk_en && issue_valid &&
      (state_q == sbsel_pkg::SBSEL_IDLE);

   // Decode of the presented field
   assign pick = sbsel_pick(field_code, src);

   // Next-state and next-word computation
   always_comb begin
      state_d = state_q;
      hold_d = second_bus_hold_q;
      loaded_d = loaded_q;
      freeze_d = freeze_q;
      if (clk_en) begin
         loaded_d = 1'b0;
         case (state_q)
            sbsel_pkg::SBSEL_IDLE: begin
               if (issue_valid) begin
                  if (field_code == `SB_OPERAND && operand_busy) begin
                     // Operand not ready: hold the CPU
                     state_d = sbsel_pkg::SBSEL_WAIT_OPERAND;
                     freeze_d = 1'b1;
                  end else if (pick[16]) begin
                     hold_d = pick[15:0];
                     loaded_d = 1'b1;
                  end
               end
            end
            sbsel_pkg::SBSEL_WAIT_OPERAND: begin
               if (!operand_busy) begin
                  // Memory operation done: finish the load
                  hold_d = src.operand_reg;
                  loaded_d = 1'b1;
                  freeze_d = 1'b0;
                  state_d = sbsel_pkg::SBSEL_IDLE;
               end
            end
            default: begin
               state_d = sbsel_pkg::SBSEL_IDLE;
               freeze_d = 1'b0;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sbsel_pkg::SBSEL_IDLE;
         second_bus_hold_q <= `SB_HOLD_RST;
         loaded_q <= 1'b0;
         freeze_q <= 1'b0;
      end else begin
         state_q <= state_d;
         second_bus_hold_q <= hold_d;
         loaded_q <= loaded_d;
         freeze_q <= freeze_d;
      end
   end

   // Checks of the decoded loads
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   cond_copy_a: assert property (
      take && field_code == `SB_COND |=>
      second_bus_hold_q[9:8] == $past(src.status_word[7:6]) &&
      second_bus_hold_q[15:10] == 6'h00 &&
      second_bus_hold_q[6:0] == 7'h00)
      else $error("condition code copy wrong");

   cond_zero_a: assert property (
      take && field_code == `SB_COND |=>
      second_bus_hold_q[7] == ($past(src.status_word[7:6]) == 2'h0))
      else $error("condition code zero flag wrong");

   instr_load_a: assert property (
      take && field_code == `SB_INSTR |=>
      second_bus_hold_q == $past(src.current_instruction_reg) && loaded_q)
      else $error("instruction load wrong");

   grp1_load_a: assert property (
      take && field_code == `SB_GRP1 |=>
      second_bus_hold_q == $past(src.special_signals_group_one))
      else $error("group one load wrong");

   grp2_load_a: assert property (
      take && field_code == `SB_GRP2 |=>
      second_bus_hold_q == $past(src.special_signals_group_two))
      else $error("group two load wrong");

   cnt_high_a: assert property (
      take && field_code == `SB_CNTH |=>
      second_bus_hold_q == {6'h00, $past(src.loop_counter_reg), 4'h0})
      else $error("counter high placement wrong");

   cnt_low_a: assert property (
      take && field_code == `SB_CNTL |=>
      second_bus_hold_q == {$past(src.loop_counter_reg), 10'h000})
      else $error("counter low placement wrong");

   dbase_load_a: assert property (
      take && field_code == `SB_DBASE |=>
      second_bus_hold_q == $past(src.data_base_reg))
      else $error("data base load wrong");

   dlimit_load_a: assert property (
      take && field_code == `SB_DLIM |=>
      second_bus_hold_q == $past(src.data_limit_reg))
      else $error("data limit load wrong");

   devnum_place_a: assert property (
      take && field_code == `SB_DEVNUM |=>
      second_bus_hold_q == {$past(src.device_number_reg), 8'h00})
      else $error("device number placement wrong");

   dirin_load_a: assert property (
      take && field_code == `SB_DIRIN |=>
      second_bus_hold_q == $past(src.direct_input_data_reg))
      else $error("direct input load wrong");

   unit_place_a: assert property (
      take && field_code == `SB_UNIT |=>
      second_bus_hold_q[7:4] == $past(src.unit_number_reg) &&
      second_bus_hold_q[3:0] == 4'h0 && second_bus_hold_q[12:8] == 5'h00 &&
      second_bus_hold_q[15:14] == 2'h0)
      else $error("unit number placement wrong");

   unit_flag_a: assert property (
      take && field_code == `SB_UNIT |=> second_bus_hold_q[13])
      else $error("unit flag bit not set");

   operand_load_a: assert property (
      take && field_code == `SB_OPERAND && !operand_busy |=>
      second_bus_hold_q == $past(src.operand_reg) && !freeze_q)
      else $error("operand load wrong");

   operand_freeze_a: assert property (
      take && field_code == `SB_OPERAND && operand_busy |=>
      freeze_q && !loaded_q && $stable(second_bus_hold_q))
      else $error("operand freeze missing");

   operand_release_a: assert property (
      state_q == sbsel_pkg::SBSEL_WAIT_OPERAND && clk_en &&
      !operand_busy |=>
      !freeze_q && loaded_q && second_bus_hold_q == $past(src.operand_reg))
      else $error("operand release wrong");

   freeze_hold_a: assert property (
      freeze_q && operand_busy |=> freeze_q && !loaded_q)
      else $error("freeze dropped while busy");

   pc_load_a: assert property (
      take && field_code == `SB_PC |=>
      second_bus_hold_q == $past(src.program_counter))
      else $error("program counter load wrong");

   preadd_load_a: assert property (
      take && field_code == `SB_PREADD |=>
      second_bus_hold_q == $past(src.pre_adder_output))
      else $error("pre-adder load wrong");

   pbase_load_a: assert property (
      take && field_code == `SB_PBASE |=>
      second_bus_hold_q == $past(src.program_base_reg))
      else $error("program base load wrong");

   nop_keep_a: assert property (
      take && field_code == `SB_NOP |=>
      $stable(second_bus_hold_q) && !loaded_q)
      else $error("no-operation changed the word");

   keep_word_a: assert property (
      take && field_code == `SB_KEEP |=>
      $stable(second_bus_hold_q) && !loaded_q)
      else $error("keep code changed the word");

   enable_freeze_a: assert property (
      !clk_en |=> $stable(second_bus_hold_q) && $stable(freeze_q) &&
      $stable(loaded_q))
      else $error("state moved with enable low");

endmodule

// ==== tb/sbsel_seq.sv ====
// Sequencer model: presents S-Bus field codes to the selector.
// Assumes the bench calls issue from its falling-edge driver.
`timescale 1ns/10ps

module sbsel_seq (
   input wire logic clk,
   output logic issue_valid,
   output logic [4:0] field_code
);

   // Idle until the first request
   initial begin
      issue_valid = 1'b0;
      field_code = 5'h1F;
   end

   // Present one code for one cycle, then release the field
   task automatic issue(input logic [4:0] code);
      @(negedge clk);
      issue_valid = 1'b1;
      field_code = code;
      @(negedge clk);
      issue_valid = 1'b0;
      field_code = ~code; // Released field no longer shows last code
   endtask

endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the S-Bus source selector.
// Assumes the selector, its package and the sequencer model.
`timescale 1ns/10ps
`include "sbsel_params.svh"

module tb;

   typedef struct packed {
      logic [4:0] code;
      logic [15:0] exp;
      logic ld;
   } sbsel_row_type;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic operand_busy = 1'b0;
   logic issue_valid;
   logic [4:0] field_code;
   sbsel_pkg::sbsel_src_type src;
   logic [15:0] hold;
   logic [15:0] prev;
   logic loaded;
   logic freeze;
   int failures = 0;
   int tests_run = 0;
   sbsel_row_type rows [17];
   logic [4:0] unlisted [13] = '{5'h0B, 5'h11, 5'h08, 5'h1B, 5'h1A,
      5'h03, 5'h19, 5'h18, 5'h13, 5'h01, 5'h14, 5'h07, 5'h0E};

   // Clock
   always #5 clk = ~clk;

   sbsel_top sbsel_top_i (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .issue_valid(issue_valid),
      .field_code(field_code),
      .operand_busy(operand_busy),
      .src(src),
      .second_bus_hold_q(hold),
      .loaded_q(loaded),
      .freeze_q(freeze)
   );

   sbsel_seq sbsel_seq_i (
      .clk(clk),
      .issue_valid(issue_valid),
      .field_code(field_code)
   );

   // Compare tasks
   task automatic chk16(input string name, input logic [15:0] exp);
      tests_run++;
      if (hold !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, hold);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic results();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      failures++;
      results();
   end

   // Main sequence
   initial begin
      src = '{16'hC1A5, 16'h1F01, 16'h2F02, 16'hDB0B, 16'hD1CE, 16'h10DA,
         16'h0B0D, 16'h9C01, 16'hADD0, 16'hB0B5, 16'h0080, 6'h2D, 8'hA5,
         4'h9};
      rows[0] = '{`SB_INSTR, 16'hC1A5, 1'b1};
      rows[1] = '{`SB_NOP, 16'hC1A5, 1'b0};
      rows[2] = '{`SB_PREADD, 16'hADD0, 1'b1};
      rows[3] = '{`SB_GRP1, 16'h1F01, 1'b1};
      rows[4] = '{`SB_KEEP, 16'h1F01, 1'b0};
      rows[5] = '{`SB_UNIT, 16'h2090, 1'b1};
      rows[6] = '{`SB_GRP2, 16'h2F02, 1'b1};
      rows[7] = '{`SB_DEVNUM, 16'hA500, 1'b1};
      rows[8] = '{`SB_DIRIN, 16'h10DA, 1'b1};
      rows[9] = '{`SB_CNTL, 16'hB400, 1'b1};
      rows[10] = '{`SB_CNTH, 16'h02D0, 1'b1};
      rows[11] = '{`SB_PC, 16'h9C01, 1'b1};
      rows[12] = '{`SB_DBASE, 16'hDB0B, 1'b1};
      rows[13] = '{`SB_OPERAND, 16'h0B0D, 1'b1};
      rows[14] = '{`SB_COND, 16'h0200, 1'b1};
      rows[15] = '{`SB_DLIM, 16'hD1CE, 1'b1};
      rows[16] = '{`SB_PBASE, 16'hB0B5, 1'b1};
      repeat (20) @(negedge clk);
      chk16("hold in reset", 16'h0000);
      chk1("freeze in reset", 1'b0, freeze);
      rst_n = 1'b1;
      // Ordinary codes
      foreach (rows[i]) begin
         sbsel_seq_i.issue(rows[i].code);
         chk16("row word", rows[i].exp);
         chk1("row loaded", rows[i].ld, loaded);
      end
      // Condition code with both copied bits clear and other bits set, then with only bit 6 set
      src.status_word = 16'hFF3F;
      sbsel_seq_i.issue(`SB_COND);
      chk16("condition zero", 16'h0080);
      src.status_word = 16'h0040;
      sbsel_seq_i.issue(`SB_COND);
      chk16("condition one", 16'h0100);
      // Codes owned by other logic leave the word alone
      foreach (unlisted[i]) begin
         sbsel_seq_i.issue(unlisted[i]);
         chk16("unlisted word", 16'h0100);
         chk1("unlisted loaded", 1'b0, loaded);
      end
      // Disabled clock ignores a request
      clk_en = 1'b0;
      sbsel_seq_i.issue(`SB_INSTR);
      chk16("disabled word", 16'h0100);
      clk_en = 1'b1;
      // Operand load during a busy memory operation freezes
      operand_busy = 1'b1;
      src.operand_reg = 16'h5A5A;
      sbsel_seq_i.issue(`SB_OPERAND);
      chk1("freeze set", 1'b1, freeze);
      sbsel_seq_i.issue(`SB_INSTR);
      chk1("freeze held", 1'b1, freeze);
      chk16("frozen word", 16'h0100);
      src.operand_reg = 16'h6B6B;
      operand_busy = 1'b0;
      @(negedge clk);
      chk1("freeze done", 1'b0, freeze);
      chk1("late load", 1'b1, loaded);
      chk16("late word", 16'h6B6B);
      // Enable low keeps the load pulse standing
      clk_en = 1'b0;
      @(negedge clk);
      chk1("pulse held", 1'b1, loaded);
      clk_en = 1'b1;
      // Reset in mid-run clears the word at once
      rst_n = 1'b0;
      #1;
      chk16("mid reset", 16'h0000);
      @(negedge clk);
      rst_n = 1'b1;
      sbsel_seq_i.issue(`SB_INSTR);
      chk16("after reset", 16'hC1A5);
      results();
   end

endmodule
